//--- design/jsm_map.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 200 MHz REF_CLK_IN, 16-bit registers in the low half of APB words
// Notes: offsets below are word indices, byte address = 4 * index
`ifndef JSM_MAP_SVH
`define JSM_MAP_SVH
// ==========================================================================
// register indices
`define JSM_IDX_JACK 8'h78
`define JSM_IDX_MISC 8'h7A
`define JSM_IDX_ROUTE 8'h70
`define JSM_IDX_IRQ_STAT 8'h71
`define JSM_IDX_IRQ_CLR 8'h72
`define JSM_IDX_IRQ_EN 8'h73
// ==========================================================================
// jack register layout
`define JSM_JK_INT_MASK 16'h5503
`define JSM_JK_ST_MASK 16'hAA0C
`define JSM_JK_CTL_MASK 16'h00B0
`define JSM_JK_PATH_BIT 7
`define JSM_JK_MD3_BIT 5
`define JSM_JK_MD2_BIT 4
// ==========================================================================
// misc register layout
`define JSM_MISC_MASK 16'hFF1C
`define JSM_MISC_RESET 16'h0000
`define JSM_MISC_POL_B_BIT 15
`define JSM_MISC_HP_HI_BIT 14
`define JSM_MISC_HP_LO_BIT 13
`define JSM_MISC_LO_SEL_BIT 12
`define JSM_MISC_POL_A_BIT 11
`define JSM_MISC_BIAS_HI_BIT 10
`define JSM_MISC_BIAS_LO_BIT 8
`define JSM_MISC_LOHP_BIT 4
`define JSM_MISC_GPO_BIT 3
`define JSM_MISC_MIX_BIT 2
`define JSM_BIAS_CODE_HIZ 3'h0
`define JSM_BIAS_CODE_2V25 3'h1
`define JSM_BIAS_CODE_0V 3'h2
`define JSM_BIAS_CODE_3V70 3'h4
// ==========================================================================
// own registers and timing
`define JSM_ROUTE_MASK 16'h0001
`define JSM_IRQ_MASK 16'h007F
`define JSM_REG_RESET 16'h0000
`define JSM_CLK_MHZ 200
`define JSM_DEBOUNCE_NS 1000
`define JSM_DEBOUNCE_CYC ((`JSM_DEBOUNCE_NS * `JSM_CLK_MHZ + 999) / 1000)
`endif

//--- design/jsm_pkg.sv
// Purpose: shared types of the jack sense and misc control block
// Assumes: nothing
// Notes: encodings of the decoded outputs are fixed by the enum order
package jsm_pkg;
	typedef enum logic [1:0] {JSM_BIAS_HIZ, JSM_BIAS_2V25, JSM_BIAS_0V,
		JSM_BIAS_3V70} jsm_bias_t;
	typedef enum logic [1:0] {JSM_HP_MIXER, JSM_HP_SURROUND,
		JSM_HP_CLFE} jsm_hp_src_t;
	typedef enum logic [1:0] {JSM_FLT_PRIME, JSM_FLT_STABLE,
		JSM_FLT_SETTLE} jsm_flt_state_t;
endpackage

//--- design/jsm_reg_if.sv
// Purpose: register access strobes between bus slave and register core
// Assumes: one access per cycle
// Notes: err is the core's answer to an index it does not hold
`timescale 1ns/100ps
interface jsm_reg_if;
	logic wr;
	logic [7:0] idx;
	logic [15:0] wdata;
	logic [1:0] wlane;
	logic [15:0] rdata;
	logic err;
	modport bus(output wr, output idx, output wdata, output wlane,
		input rdata, input err);
	modport core(input wr, input idx, input wdata, input wlane,
		output rdata, output err);
endinterface

//--- design/jsm_apb.sv
// Purpose: APB slave front end with registered read data
// Assumes: master keeps address and data steady through the access phase
// Notes: read data is captured in the setup cycle, so pready never waits
`timescale 1ns/100ps
module jsm_apb import jsm_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	jsm_reg_if.bus reg_if
);
	logic [31:0] prdata_q;
	logic err_q;
	wire setup = psel_in & ~penable_in;
	wire access = psel_in & penable_in;
	wire addr_ok = (paddr_in[11:10] == 2'h0) && (paddr_in[1:0] == 2'h0);
	assign reg_if.idx = paddr_in[9:2];
	assign reg_if.wdata = pwdata_in[15:0];
	assign reg_if.wlane = pstrb_in[1:0];
	assign reg_if.wr = access & pwrite_in & addr_ok & ~reg_if.err;
	assign pready_out = 1'b1;
	assign prdata_out = prdata_q;
	assign pslverr_out = err_q & access;
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= pwrite_in ? 32'h0000_0000 : {16'h0000, reg_if.rdata};
			err_q <= ~addr_ok | reg_if.err;
		end
	end
endmodule

//--- design/jsm_sense.sv
// Purpose: per-jack settle filter producing stable presence and change pulses
// Assumes: levels already corrected for switch polarity
// Notes: first sample after reset is taken as is, so boot raises no event
`timescale 1ns/100ps
`include "jsm_map.svh"
module jsm_sense import jsm_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [5:0] level_in,
	output logic [5:0] state_out,
	output logic [5:0] change_out
);
	genvar j;
	generate
		for (j = 0; j < 6; j++)
		begin : g_jack
			jsm_flt_state_t st_q, st_d;
			logic [7:0] cnt_q, cnt_d;
			logic lvl_q, lvl_d, chg_q, chg_d;
			// a level must differ for the whole settle time to count as valid
			always_comb
			begin
				st_d = st_q;
				cnt_d = cnt_q;
				lvl_d = lvl_q;
				chg_d = 1'b0;
				case (st_q)
					JSM_FLT_PRIME:
					begin
						lvl_d = level_in[j];
						st_d = JSM_FLT_STABLE;
					end
					JSM_FLT_STABLE:
						if (level_in[j] != lvl_q)
						begin
							st_d = JSM_FLT_SETTLE;
							cnt_d = 8'h01;
						end
					JSM_FLT_SETTLE:
						if (level_in[j] == lvl_q)
							st_d = JSM_FLT_STABLE;
						else if (cnt_q == 8'(`JSM_DEBOUNCE_CYC))
						begin
							lvl_d = level_in[j];
							chg_d = 1'b1;
							st_d = JSM_FLT_STABLE;
						end
						else
							cnt_d = cnt_q + 8'h01;
					default: st_d = JSM_FLT_PRIME;
				endcase
			end
			always_ff @(posedge clk_in)
			begin
				if (srst_in)
				begin
					st_q <= JSM_FLT_PRIME;
					cnt_q <= 8'h00;
					lvl_q <= 1'b0;
					chg_q <= 1'b0;
				end
				else
				begin
					st_q <= st_d;
					cnt_q <= cnt_d;
					lvl_q <= lvl_d;
					chg_q <= chg_d;
				end
			end
			assign state_out[j] = lvl_q;
			assign change_out[j] = chg_q;
		end
	endgenerate
endmodule

//--- design/jsm_top.sv
// Purpose: jack detection status/control and misc output control registers
// Assumes: APB master, switch levels synchronous to REF_CLK_IN
// Notes: jacks 2,4,6 sit on sense A, jacks 3,5,7 on sense B
//
// Summary of operation
// R1: jack register fields are read/write except presence bits, read only.
// R2: a valid settled change of a jack sets that jack's flag.
// R3: flag reads 0 when idle, 1 once its jack raised an interrupt.
// R4: host writes 0 to clear a flag; writing 1 raises software interrupt.
// R5: jack interrupt leaves on the path picked by the route select bit; here only the lower pair uses it, upper jacks follow the path bit.
// R6: upper four presence bits follow detection: 0 absent, 1 present.
// R7: lower pair mode bits: 0 polling (default), 1 events raise interrupts.
// R8: path bit: 0 signals slot 12 bit 0, 1 signals slot 6 valid.
// R9: mic mix enable mixes both channels and masks dual-mic and source.
// R10: general output pin low for 0 (default), high for 1.
// R11: line-out headphone drive on when set, powered down when clear.
// R12: bias 000 hi-z, 001 2.25 V, 010 0 V, 100 3.70 V; others illegal.
// R13: line-out source: 0 analog mixer (default), 1 surround converters.
// R14: headphone source: 00 mixer, 01 surround, 1x center/LFE converters.
// R15: sense A polarity: 0 normally-open (default), 1 normally-closed.
// R16: sense B polarity: 0 normally-open (default), 1 normally-closed.
// R17: polarity is applied before detection so presence reads 1 inserted.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "jsm_map.svh"
module jsm_top import jsm_pkg::*;
(
	input wire logic REF_CLK_IN,
	input wire logic SRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [3:0] PSTRB_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic [2:0] JACK_SW_A_IN,
	input wire logic [2:0] JACK_SW_B_IN,
	input wire logic DUAL_MIC_SELECT_IN,
	input wire logic MIC_SOURCE_SELECT_IN,
	output logic MIC_CHANNEL_MIX_ENABLE_OUT,
	output logic DUAL_MIC_SELECT_EFF_OUT,
	output logic MIC_SOURCE_SELECT_EFF_OUT,
	output logic GENERAL_OUTPUT_LEVEL_OUT,
	output logic LINEOUT_HEADPHONE_DRIVE_ENABLE_OUT,
	output logic [1:0] LINEIN_BIAS_SELECT_OUT,
	output logic LINEOUT_SOURCE_SELECT_OUT,
	output logic [1:0] HEADPHONE_SOURCE_SELECT_OUT,
	output logic SLOT12_IRQ_OUT,
	output logic SLOT6_IRQ_OUT,
	output logic IRQ_OUT
);
	// ======================================================================
	// helpers
	// byte strobes widened to a bit mask; shared by the merge and the clear
	function automatic logic [15:0] jsm_lanes(
		input logic [1:0] lane
	);
		jsm_lanes = {{8{lane[1]}}, {8{lane[0]}}};
	endfunction

	function automatic logic [15:0] jsm_merge(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0] lane,
		input logic [15:0] mask
	);
		logic [15:0] sel;
		sel = jsm_lanes(lane) & mask;
		jsm_merge = (old_v & ~sel) | (new_v & sel);
	endfunction

	// ======================================================================
	// bus front end
	jsm_reg_if reg_if();

	jsm_apb u_apb
	(
		.clk_in(REF_CLK_IN),
		.srst_in(SRST_IN),
		.psel_in(PSEL_IN),
		.penable_in(PENABLE_IN),
		.pwrite_in(PWRITE_IN),
		.paddr_in(PADDR_IN),
		.pwdata_in(PWDATA_IN),
		.pstrb_in(PSTRB_IN),
		.prdata_out(PRDATA_OUT),
		.pready_out(PREADY_OUT),
		.pslverr_out(PSLVERR_OUT),
		.reg_if(reg_if)
	);

	wire hit_jack = reg_if.idx == `JSM_IDX_JACK;
	wire hit_misc = reg_if.idx == `JSM_IDX_MISC;
	wire hit_route = reg_if.idx == `JSM_IDX_ROUTE;
	wire hit_stat = reg_if.idx == `JSM_IDX_IRQ_STAT;
	wire hit_clr = reg_if.idx == `JSM_IDX_IRQ_CLR;
	wire hit_en = reg_if.idx == `JSM_IDX_IRQ_EN;
	wire wr_jack = reg_if.wr & hit_jack;
	wire wr_misc = reg_if.wr & hit_misc;
	wire wr_route = reg_if.wr & hit_route;
	wire wr_clr = reg_if.wr & hit_clr;
	wire wr_en = reg_if.wr & hit_en;
	wire [15:0] wdata = reg_if.wdata;
	wire [1:0] wlane = reg_if.wlane;

	// an index not held here answers with an error and the write is dropped
	assign reg_if.err = ~(hit_jack | hit_misc | hit_route | hit_stat |
		hit_clr | hit_en);

	// ======================================================================
	// register state
	logic [15:0] jk_ctl_q, jk_ctl_d;
	logic [15:0] misc_q, misc_d;
	logic [15:0] route_q, route_d;
	logic [15:0] irq_en_q, irq_en_d;
	logic [15:0] irq_stat_q, irq_stat_d;
	logic [5:0] flag_q, flag_d;

	assign jk_ctl_d = wr_jack ?
		jsm_merge(jk_ctl_q, wdata, wlane, `JSM_JK_CTL_MASK) : jk_ctl_q; // R1
	assign misc_d = wr_misc ?
		jsm_merge(misc_q, wdata, wlane, `JSM_MISC_MASK) : misc_q;
	assign route_d = wr_route ?
		jsm_merge(route_q, wdata, wlane, `JSM_ROUTE_MASK) : route_q;
	assign irq_en_d = wr_en ?
		jsm_merge(irq_en_q, wdata, wlane, `JSM_IRQ_MASK) : irq_en_q;

	wire path_sel = jk_ctl_q[`JSM_JK_PATH_BIT];
	wire [1:0] lower_mode = {jk_ctl_q[`JSM_JK_MD3_BIT],
		jk_ctl_q[`JSM_JK_MD2_BIT]};
	wire route_sel = route_q[0];
	wire pol_a = misc_q[`JSM_MISC_POL_A_BIT];
	wire pol_b = misc_q[`JSM_MISC_POL_B_BIT];

	// ======================================================================
	// sensing: index 0..5 stands for jacks 2..7
	logic [5:0] sw_level;
	logic [5:0] present;
	logic [5:0] changed;

	assign sw_level = {JACK_SW_B_IN[2] ^ pol_b, JACK_SW_A_IN[2] ^ pol_a,
		JACK_SW_B_IN[1] ^ pol_b, JACK_SW_A_IN[1] ^ pol_a,
		JACK_SW_B_IN[0] ^ pol_b, JACK_SW_A_IN[0] ^ pol_a}; // R15 R16 R17

	jsm_sense u_sense
	(
		.clk_in(REF_CLK_IN),
		.srst_in(SRST_IN),
		.level_in(sw_level),
		.state_out(present),
		.change_out(changed)
	);

	// ======================================================================
	// jack interrupt flags
	wire [5:0] flag_wval = {wdata[14], wdata[12], wdata[10], wdata[8],
		wdata[1], wdata[0]};
	wire [5:0] flag_wsel = {{4{wlane[1]}}, {2{wlane[0]}}} & {6{wr_jack}};
	wire [5:0] flag_arm = {4'hF, lower_mode}; // R7
	wire [5:0] flag_set = changed & flag_arm; // R2

	genvar j;
	generate
		for (j = 0; j < 6; j++)
		begin : g_flag
			// a sensed change in the clearing cycle still leaves the flag set
			assign flag_d[j] = flag_set[j] |
				(flag_wsel[j] ? flag_wval[j] : flag_q[j]); // R3 R4
		end
	endgenerate

	// writing a one to any flag counts as a software interrupt request
	wire sw_irq = |(flag_wsel & flag_wval); // R4

	// ======================================================================
	// host interrupt status: bits 5..0 jack changes, bit 6 software request
	wire [15:0] irq_event = {9'h000, sw_irq, changed};
	wire [15:0] irq_clear = wr_clr ?
		(wdata & jsm_lanes(wlane)) : 16'h0000;

	assign irq_stat_d = (irq_event | (irq_stat_q & ~irq_clear)) &
		`JSM_IRQ_MASK;

	// ======================================================================
	// read data
	wire [15:0] jack_st_vec = {present[5], 1'b0, present[4], 1'b0,
		present[3], 1'b0, present[2], 1'b0, 4'h0, present[1], present[0],
		2'h0}; // R6
	wire [15:0] jack_flag_vec = {1'b0, flag_q[5], 1'b0, flag_q[4], 1'b0,
		flag_q[3], 1'b0, flag_q[2], 6'h00, flag_q[1], flag_q[0]};
	wire [15:0] jack_rd = jk_ctl_q | jack_st_vec | jack_flag_vec; // R1

	assign reg_if.rdata = hit_jack ? jack_rd :
		hit_misc ? misc_q :
		hit_route ? route_q :
		hit_stat ? irq_stat_q :
		hit_en ? irq_en_q :
		16'h0000;

	// ======================================================================
	// link interrupt paths
	wire upper_irq = |flag_q[5:2];
	wire lower_irq = |flag_q[1:0];
	wire slot12_d = (upper_irq & ~path_sel) | (lower_irq & ~route_sel); // R8
	wire slot6_d = (upper_irq & path_sel) | (lower_irq & route_sel); // R5
	// level output: holds until software clears the status or the enable
	wire irq_d = |(irq_stat_q & irq_en_q);

	// ======================================================================
	// misc output decode
	wire mix_en = misc_q[`JSM_MISC_MIX_BIT];
	wire [2:0] bias_code = misc_q[`JSM_MISC_BIAS_HI_BIT:`JSM_MISC_BIAS_LO_BIT];
	wire [1:0] hp_code = misc_q[`JSM_MISC_HP_HI_BIT:`JSM_MISC_HP_LO_BIT];
	jsm_bias_t bias_d;
	jsm_hp_src_t hp_d;

	// illegal bias codes fall back to hi-z rather than driving a level
	always_comb
	begin
		case (bias_code)
			`JSM_BIAS_CODE_HIZ: bias_d = JSM_BIAS_HIZ;
			`JSM_BIAS_CODE_2V25: bias_d = JSM_BIAS_2V25;
			`JSM_BIAS_CODE_0V: bias_d = JSM_BIAS_0V;
			`JSM_BIAS_CODE_3V70: bias_d = JSM_BIAS_3V70;
			default: bias_d = JSM_BIAS_HIZ;
		endcase // R12
	end

	always_comb
	begin
		case (hp_code)
			2'h0: hp_d = JSM_HP_MIXER;
			2'h1: hp_d = JSM_HP_SURROUND;
			default: hp_d = JSM_HP_CLFE;
		endcase // R14
	end

	// ======================================================================
	// output flops
	logic mix_q, dual_eff_q, src_eff_q, gpo_q, lohp_q, lineout_source_select_q;
	logic slot12_q, slot6_q, irq_q;
	jsm_bias_t bias_q;
	jsm_hp_src_t hp_q;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			jk_ctl_q <= `JSM_REG_RESET;
			misc_q <= `JSM_MISC_RESET;
			route_q <= `JSM_REG_RESET;
			irq_en_q <= `JSM_REG_RESET;
		end
		else
		begin
			jk_ctl_q <= jk_ctl_d;
			misc_q <= misc_d;
			route_q <= route_d;
			irq_en_q <= irq_en_d;
		end
	end

	// event state kept apart: it moves on sensed changes as well as writes
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			irq_stat_q <= `JSM_REG_RESET;
			flag_q <= 6'h00;
		end
		else
		begin
			irq_stat_q <= irq_stat_d;
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			mix_q <= 1'b0;
			dual_eff_q <= 1'b0;
			src_eff_q <= 1'b0;
		end
		else
		begin
			mix_q <= mix_en; // R9
			dual_eff_q <= DUAL_MIC_SELECT_IN & ~mix_en; // R9
			src_eff_q <= MIC_SOURCE_SELECT_IN & ~mix_en; // R9
		end
	end

	// analog controls lag their register bits by one clock, like the mic pins
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			gpo_q <= 1'b0;
			lohp_q <= 1'b0;
			lineout_source_select_q <= 1'b0;
			bias_q <= JSM_BIAS_HIZ;
			hp_q <= JSM_HP_MIXER;
		end
		else
		begin
			gpo_q <= misc_q[`JSM_MISC_GPO_BIT]; // R10
			lohp_q <= misc_q[`JSM_MISC_LOHP_BIT]; // R11
			lineout_source_select_q <= misc_q[`JSM_MISC_LO_SEL_BIT]; // R13
			bias_q <= bias_d;
			hp_q <= hp_d;
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			slot12_q <= 1'b0;
			slot6_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			slot12_q <= slot12_d;
			slot6_q <= slot6_d;
			irq_q <= irq_d;
		end
	end

	assign MIC_CHANNEL_MIX_ENABLE_OUT = mix_q;
	assign DUAL_MIC_SELECT_EFF_OUT = dual_eff_q;
	assign MIC_SOURCE_SELECT_EFF_OUT = src_eff_q;
	assign GENERAL_OUTPUT_LEVEL_OUT = gpo_q;
	assign LINEOUT_HEADPHONE_DRIVE_ENABLE_OUT = lohp_q;
	assign LINEIN_BIAS_SELECT_OUT = bias_q;
	assign LINEOUT_SOURCE_SELECT_OUT = lineout_source_select_q;
	assign HEADPHONE_SOURCE_SELECT_OUT = hp_q;
	assign SLOT12_IRQ_OUT = slot12_q;
	assign SLOT6_IRQ_OUT = slot6_q;
	assign IRQ_OUT = irq_q;
endmodule

//--- test/jsm_jack_model.sv
// Purpose: jack switch contacts seen by the two sense inputs
// Assumes: raw level 1 means the switch contacts are closed
// Notes: a normally-closed switch opens when a plug goes in
`timescale 1ns/100ps
module jsm_jack_model
(
	input wire logic [5:0] plug_in,
	input wire logic nc_a_in,
	input wire logic nc_b_in,
	output logic [2:0] sw_a_out,
	output logic [2:0] sw_b_out
);
	// ==========================================================
	// contacts
	// plug bit n is jack n+2; even jacks hang on sense A
	assign sw_a_out = {plug_in[4], plug_in[2], plug_in[0]} ^ {3{nc_a_in}};
	assign sw_b_out = {plug_in[5], plug_in[3], plug_in[1]} ^ {3{nc_b_in}};
endmodule

//--- test/jsm_top_chk.sv
// Purpose: port checks of the jack sense and misc control block
// Assumes: a register write reaches its pin two edges after the access
// Notes: reserved bias codes are taken to decode to hi-z
`timescale 1ns/100ps
`include "jsm_map.svh"
module jsm_top_chk
(
	input wire logic REF_CLK_IN,
	input wire logic SRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [3:0] PSTRB_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic MIC_CHANNEL_MIX_ENABLE_OUT,
	input wire logic DUAL_MIC_SELECT_EFF_OUT,
	input wire logic MIC_SOURCE_SELECT_EFF_OUT,
	input wire logic GENERAL_OUTPUT_LEVEL_OUT,
	input wire logic LINEOUT_HEADPHONE_DRIVE_ENABLE_OUT,
	input wire logic [1:0] LINEIN_BIAS_SELECT_OUT,
	input wire logic LINEOUT_SOURCE_SELECT_OUT,
	input wire logic [1:0] HEADPHONE_SOURCE_SELECT_OUT,
	input wire logic SLOT12_IRQ_OUT,
	input wire logic SLOT6_IRQ_OUT
);
	// ==========================================================
	// bus decode
	wire logic [7:0] idx = PADDR_IN[9:2];
	wire logic [2:0] bw = PWDATA_IN[10:8];
	wire logic hit = PADDR_IN[1:0] == 2'h0 && PADDR_IN[11:10] == 2'h0
		&& (idx == `JSM_IDX_JACK || idx == `JSM_IDX_MISC
		|| (idx >= `JSM_IDX_ROUTE && idx <= `JSM_IDX_IRQ_EN));
	wire logic acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	wire logic wr = acc && PWRITE_IN && hit;
	wire logic wm0 = wr && idx == `JSM_IDX_MISC && PSTRB_IN[0];
	wire logic wm1 = wr && idx == `JSM_IDX_MISC && PSTRB_IN[1];
	wire logic wj1 = wr && idx == `JSM_IDX_JACK && PSTRB_IN[1];
	wire logic [1:0] bias_e = bw == 3'h1 ? 2'h1 : bw == 3'h2 ? 2'h2
		: bw == 3'h4 ? 2'h3 : 2'h0;
	wire logic [1:0] hp_e = PWDATA_IN[14] ? 2'h2 : {1'b0, PWDATA_IN[13]};
	// ==========================================================
	// assertions
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (SRST_IN);
	property p_gpo;
		wm0 |-> ##2 GENERAL_OUTPUT_LEVEL_OUT == $past(PWDATA_IN[3], 2);
	endproperty
	a_gpo: assert property (p_gpo) else $error("gpo pin wrong");
	property p_lohp;
		wm0 |-> ##2
		LINEOUT_HEADPHONE_DRIVE_ENABLE_OUT == $past(PWDATA_IN[4], 2);
	endproperty
	a_lohp: assert property (p_lohp) else $error("drive wrong");
	property p_lineout_source_select;
		wm1 |-> ##2 LINEOUT_SOURCE_SELECT_OUT == $past(PWDATA_IN[12], 2);
	endproperty
	a_lineout_source_select: assert property (p_lineout_source_select) else $error("lo src wrong");
	property p_bias;
		wm1 |-> ##2 LINEIN_BIAS_SELECT_OUT == $past(bias_e, 2);
	endproperty
	a_bias: assert property (p_bias) else $error("bias wrong");
	property p_hp;
		wm1 |-> ##2 HEADPHONE_SOURCE_SELECT_OUT == $past(hp_e, 2);
	endproperty
	a_hp: assert property (p_hp) else $error("hp src wrong");
	property p_mask;
		MIC_CHANNEL_MIX_ENABLE_OUT
		|-> !DUAL_MIC_SELECT_EFF_OUT && !MIC_SOURCE_SELECT_EFF_OUT;
	endproperty
	a_mask: assert property (p_mask) else $error("mic not masked");
	property p_err;
		PSEL_IN && PENABLE_IN |-> PSLVERR_OUT == !hit;
	endproperty
	a_err: assert property (p_err) else $error("error flag wrong");
	property p_swirq;
		wj1 && PWDATA_IN[8] |-> ##2 (SLOT12_IRQ_OUT || SLOT6_IRQ_OUT);
	endproperty
	a_swirq: assert property (p_swirq) else $error("no sw irq");
	c_bias: cover property (wm1 && bw == 3'h4);
	c_err: cover property (acc && !hit);
	c_slot6: cover property ($rose(SLOT6_IRQ_OUT));
endmodule
bind jsm_top jsm_top_chk u_chk (.REF_CLK_IN, .SRST_IN, .PSEL_IN,
	.PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSTRB_IN,
	.PREADY_OUT, .PSLVERR_OUT, .MIC_CHANNEL_MIX_ENABLE_OUT,
	.DUAL_MIC_SELECT_EFF_OUT, .MIC_SOURCE_SELECT_EFF_OUT,
	.GENERAL_OUTPUT_LEVEL_OUT, .LINEOUT_HEADPHONE_DRIVE_ENABLE_OUT,
	.LINEIN_BIAS_SELECT_OUT, .LINEOUT_SOURCE_SELECT_OUT,
	.HEADPHONE_SOURCE_SELECT_OUT, .SLOT12_IRQ_OUT, .SLOT6_IRQ_OUT);

//--- test/tb_top.sv
// Purpose: self-checking bench of the jack sense and misc control block
// Assumes: pins settle two edges after a write, jacks after 200 cycles
// Notes: 210-cycle waits cover the settle count plus the flag pipeline
`timescale 1ns/100ps
`include "jsm_map.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [3:0] pst = 4'hF;
	logic [5:0] plug = 6'h00;
	logic nca = 1'b0, ncb = 1'b0, dms = 1'b1, mss = 1'b1;
	logic [31:0] prd, rdat;
	logic prdy, perr, rerr, mix, dme, mse, general_output_level, lohp, lineout_source_select, s12, s6, irq;
	logic [2:0] swa, swb;
	logic [1:0] bias, hp;
	int n_mismatch = 0;
	int check_count = 0;
	initial forever #2.5 clk = ~clk;
	jsm_jack_model u_jacks (.plug_in(plug), .nc_a_in(nca), .nc_b_in(ncb),
		.sw_a_out(swa), .sw_b_out(swb));
	jsm_top DUT (.REF_CLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
		.PSTRB_IN(pst), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
		.PSLVERR_OUT(perr), .JACK_SW_A_IN(swa), .JACK_SW_B_IN(swb),
		.DUAL_MIC_SELECT_IN(dms), .MIC_SOURCE_SELECT_IN(mss),
		.MIC_CHANNEL_MIX_ENABLE_OUT(mix), .DUAL_MIC_SELECT_EFF_OUT(dme),
		.MIC_SOURCE_SELECT_EFF_OUT(mse), .GENERAL_OUTPUT_LEVEL_OUT(general_output_level),
		.LINEOUT_HEADPHONE_DRIVE_ENABLE_OUT(lohp),
		.LINEIN_BIAS_SELECT_OUT(bias), .LINEOUT_SOURCE_SELECT_OUT(lineout_source_select),
		.HEADPHONE_SOURCE_SELECT_OUT(hp), .SLOT12_IRQ_OUT(s12),
		.SLOT6_IRQ_OUT(s6), .IRQ_OUT(irq));
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// waits out pready instead of assuming the slave answers at once
	task automatic apb(input logic w, input logic [7:0] ix,
		input logic [15:0] d);
		@(posedge clk);
		pa <= {2'h0, ix, 2'h0};
		pwr <= w;
		pwd <= {16'h0, d};
		psel <= 1'b1;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rdat = prd;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rchk(input string nm, input logic [7:0] ix,
		input logic [31:0] e);
		apb(1'b0, ix, 16'h0);
		chk(nm, rdat, e);
	endtask
	task automatic wslot(input logic [7:0] ix, input logic [15:0] d,
		input logic [2:0] e);
		apb(1'b1, ix, d);
		cyc(2);
		chk("slots irq", {s12, s6, irq}, e);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rchk("misc", `JSM_IDX_MISC, 32'h0);
		rchk("jack", `JSM_IDX_JACK, 32'h0);
		apb(1'b0, 8'h7C, 16'h0);
		chk("unmapped", rdat, 32'h0);
		chk("slverr", {31'h0, rerr}, 32'h1);
	endtask
	task automatic t_misc();
		logic [2:0] code [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
		// polarity is set only briefly here, well inside the settle count
		apb(1'b1, `JSM_IDX_MISC, 16'hF9FF);
		cyc(2);
		chk("pins", {mix, dme, mse, general_output_level, lohp, lineout_source_select, hp, bias}, 10'h279);
		rchk("misc", `JSM_IDX_MISC, 32'hF91C);
		apb(1'b1, `JSM_IDX_MISC, 16'h0000);
		cyc(2);
		chk("pins", {mix, dme, mse, general_output_level, lohp, lineout_source_select, hp, bias}, 10'h180);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, `JSM_IDX_MISC, {1'b0, i[1:0], 13'h0});
			cyc(2);
			chk("hp", hp, (i > 1) ? 2 : i);
			apb(1'b1, `JSM_IDX_MISC, {5'h0, code[i], 8'h0});
			cyc(2);
			chk("bias", bias, i);
		end
	endtask
	task automatic t_jack();
		plug <= 6'h04;
		cyc(210);
		rchk("jack", `JSM_IDX_JACK, 32'h0300);
		wslot(`JSM_IDX_IRQ_EN, 16'h007F, 3'b101);
		wslot(`JSM_IDX_JACK, 16'h0180, 3'b011);
		wslot(`JSM_IDX_JACK, 16'h0080, 3'b001);
		rchk("jack", `JSM_IDX_JACK, 32'h0280);
		wslot(`JSM_IDX_JACK, 16'h0180, 3'b011);
		rchk("status", `JSM_IDX_IRQ_STAT, 32'h44);
		wslot(`JSM_IDX_IRQ_CLR, 16'h007F, 3'b010);
		wslot(`JSM_IDX_JACK, 16'h0000, 3'b000);
		rchk("clear", `JSM_IDX_IRQ_CLR, 32'h0);
		wslot(`JSM_IDX_IRQ_EN, 16'h0000, 3'b000);
		@(posedge clk) plug <= 6'h00;
		cyc(210);
		chk("masked", {s12, s6, irq}, 3'b100);
		rchk("jack", `JSM_IDX_JACK, 32'h0100);
		wslot(`JSM_IDX_IRQ_EN, 16'h007F, 3'b101);
		wslot(`JSM_IDX_JACK, 16'h0000, 3'b001);
		wslot(`JSM_IDX_IRQ_CLR, 16'h007F, 3'b000);
	endtask
	// status bits set in polling mode too, so the enabled level irq rises
	task automatic t_lower();
		@(posedge clk) plug <= 6'h01;
		cyc(210);
		rchk("jack", `JSM_IDX_JACK, 32'h0004);
		chk("polled", {s12, s6, irq}, 3'b001);
		wslot(`JSM_IDX_ROUTE, 16'h0001, 3'b001);
		wslot(`JSM_IDX_JACK, 16'h0010, 3'b001);
		@(posedge clk) plug <= 6'h00;
		cyc(210);
		rchk("jack", `JSM_IDX_JACK, 32'h0011);
		chk("route", {s12, s6, irq}, 3'b011);
		wslot(`JSM_IDX_ROUTE, 16'h0000, 3'b101);
		wslot(`JSM_IDX_JACK, 16'h0000, 3'b001);
		wslot(`JSM_IDX_IRQ_CLR, 16'h007F, 3'b000);
	endtask
	task automatic t_pol();
		@(posedge clk);
		nca <= 1'b1;
		ncb <= 1'b1;
		apb(1'b1, `JSM_IDX_MISC, 16'h8800);
		plug <= 6'h18;
		cyc(210);
		rchk("jack", `JSM_IDX_JACK, 32'h3C00);
		rchk("status", `JSM_IDX_IRQ_STAT, 32'h18);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_misc();
		t_jack();
		t_lower();
		t_pol();
		stop_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule
